// ==== design/fpp_pkg.sv ====
// constants, types and register map of the flash protect and program controller
// assumes an apb slave of 32-bit data on a 125 mhz clock, synchronous reset
package fpp_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_ADDR = 8'h00;
   localparam logic [7:0] OFF_WDATA = 8'h04;
   localparam logic [7:0] OFF_CMD = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0c;
   localparam logic [7:0] OFF_RIS = 8'h10;
   localparam logic [7:0] OFF_IM = 8'h14;
   localparam logic [7:0] OFF_MIS = 8'h18;
   localparam logic [7:0] OFF_ICLR = 8'h1c;
   localparam logic [7:0] OFF_PROT = 8'h20;
   localparam logic [7:0] OFF_USER0 = 8'h24;
   localparam logic [7:0] OFF_USER1 = 8'h28;
   localparam logic [7:0] OFF_RDATA = 8'h2c;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_PROG = 0;
   localparam int CMD_ERASE = 1;
   localparam int CMD_READ = 2;
   localparam int CMD_PSAVE = 3;
   localparam int CMD_USAVE = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_FAIL = 1;
   localparam int NINT = 7;
   localparam int INT_ACCESS = 0;
   localparam int INT_DONE = 1;
   localparam int INT_NVS = 2;
   localparam int INT_VOLT = 3;
   localparam int INT_DATA = 4;
   localparam int INT_ERASE = 5;
   localparam int INT_PROG = 6;
   // ----------------------------------------------------------------
   // values and timing
   // ----------------------------------------------------------------
   localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
   localparam logic [31:0] USER_BLANK = 32'hffff_ffff;
   localparam logic [NINT-1:0] RIS_RESET = 7'h00;
   localparam logic [NINT-1:0] IM_RESET = 7'h00;
   localparam int CLK_NS = 8;
   localparam int SAVE_TIME_NS = 40;
   localparam int SAVE_CYC = (SAVE_TIME_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      prot_full_access = 2'h0,
      prot_no_modify = 2'h1,
      prot_fetch_only = 2'h2
   } fpp_prot_t;
   typedef enum logic [4:0] {
      st_idle = 5'h01,
      st_fetch = 5'h02,
      st_check = 5'h04,
      st_erase = 5'h08,
      st_save = 5'h10
   } fpp_state_t;
endpackage : fpp_pkg

// ==== design/fpp_mem_if.sv ====
// memory port bundle between the sequencer and the flash array
// assumes one write and one registered read per clock
`timescale 1ns/1ps
interface fpp_mem_if #(parameter int AW = 8);
   logic we;
   logic [AW-1:0] waddr;
   logic [31:0] wdata;
   logic re;
   logic [AW-1:0] raddr;
   logic [31:0] rdata;
   modport ctl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface : fpp_mem_if

// ==== design/fpp_mem.sv ====
// flash array model: word memory, registered read data
// assumes contents survive reset; blank state is reached by erase only
`timescale 1ns/1ps
module fpp_mem #(parameter int WORDS = 256) (
   input wire logic clk,
   input wire logic rst,
   fpp_mem_if.mem mp
);
   logic [31:0] cells [WORDS];
   logic [31:0] rdata_q;
   // ----------------------------------------------------------------
   // array write and read
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (mp.we) begin
         cells[mp.waddr] <= mp.wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (mp.re) begin
         rdata_q <= cells[mp.raddr];
      end
   end
   assign mp.rdata = rdata_q;
endmodule : fpp_mem

// ==== design/fpp_nvstore.sv ====
// nonvolatile copies of protection and user words
// assumes only cold_rst (factory blank) clears them; normal reset does not
`timescale 1ns/1ps
module fpp_nvstore import fpp_pkg::*; #(parameter int NBLK = 16) (
   input wire logic clk,
   input wire logic cold_rst,
   input wire logic psave,
   input wire logic usave,
   input wire logic [2*NBLK-1:0] prot_in,
   input wire logic [31:0] user0_in,
   input wire logic [31:0] user1_in,
   output logic [2*NBLK-1:0] nv_prot,
   output logic [31:0] nv_user0,
   output logic [31:0] nv_user1
);
   // ----------------------------------------------------------------
   // commit on save pulses
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (cold_rst) begin
         nv_prot <= '0;
      end else if (psave) begin
         nv_prot <= prot_in;
      end
   end
   always_ff @(posedge clk) begin
      if (cold_rst) begin
         nv_user0 <= USER_BLANK;
         nv_user1 <= USER_BLANK;
      end else if (usave) begin
         nv_user0 <= user0_in;
         nv_user1 <= user1_in;
      end
   end
   AST_PSAVE_COMMIT: assert property (@(posedge clk) disable iff (cold_rst)
      psave |=> (nv_prot == $past(prot_in)) ##1 $stable(nv_prot) || $past(psave))
      else $error("protection save not committed");
   AST_USAVE_COMMIT: assert property (@(posedge clk) disable iff (cold_rst)
      usave |=> nv_user0 == $past(user0_in) && nv_user1 == $past(user1_in))
      else $error("user save not committed");
endmodule : fpp_nvstore

// ==== design/fpp_ctrl.sv ====
// flash protect and program controller top: apb registers, sequencer, fetch port
// assumes COLD_RESET is raised once before first use; inputs synchronous to CLK
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fpp_ctrl import fpp_pkg::*; #(
   parameter int WORDS = 256,
   parameter int BLK_WORDS = 16
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic COLD_RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic IF_REQ,
   input wire logic [31:0] IF_ADDR,
   output logic IF_READY,
   output logic IF_RVALID,
   output logic [31:0] IF_RDATA,
   input wire logic NVS_EVT,
   input wire logic VOLT_ERR,
   output logic BUSY,
   output logic IRQ
);
   localparam int AW = $clog2(WORDS);
   localparam int NBLK = WORDS / BLK_WORDS;
   localparam int OW = $clog2(BLK_WORDS);
   localparam int BW = AW - OW;
   localparam int SW = $clog2(SAVE_CYC + 1);
   localparam logic [OW-1:0] LAST_WORD = OW'(BLK_WORDS - 1);

   fpp_state_t state_q;
   logic [31:0] addr_q, wdata_q, rdata_q, user0_q, user1_q, prdata_q;
   logic [NINT-1:0] ris_q, im_q, set_v, clr_v;
   logic [NBLK-1:0][1:0] prot_q;
   logic [2*NBLK-1:0] nv_prot;
   logic [31:0] nv_user0, nv_user1;
   logic [4:0] op_q;
   logic [AW-1:0] op_word_q;
   logic [OW-1:0] cnt_q;
   logic [SW-1:0] save_cnt_q;
   logic fail_q, if_rvalid_q, psave_p, usave_p;
   logic wr_acc, rd_setup, hit, cmd_wr, prot_wr, idle;
   logic in_range, aligned, addr_ok, prot_ok, go, refuse_prot, refuse_addr;
   logic [4:0] cmd_sel;
   logic [31:0] rd_d;
   logic [AW-1:0] word_idx;
   logic [BW-1:0] blk;
   logic [1:0] cur_prot, new_prot;
   logic data_bad, prog_end, erase_end;

   fpp_mem_if #(.AW(AW)) mif ();

   fpp_mem #(.WORDS(WORDS)) u_mem (
      .clk(CLK),
      .rst(RESET),
      .mp(mif.mem)
   );

   fpp_nvstore #(.NBLK(NBLK)) u_nv (
      .clk(CLK),
      .cold_rst(COLD_RESET),
      .psave(psave_p),
      .usave(usave_p),
      .prot_in(prot_q),
      .user0_in(user0_q),
      .user1_in(user1_q),
      .nv_prot(nv_prot),
      .nv_user0(nv_user0),
      .nv_user1(nv_user1)
   );

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign wr_acc = PSEL & PENABLE & PWRITE;
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
   assign idle = (state_q == st_idle);
   assign cmd_wr = wr_acc & (PADDR == OFF_CMD);
   assign prot_wr = wr_acc & (PADDR == OFF_PROT) & idle;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~hit;
   assign PRDATA = prdata_q;

   always_comb begin
      hit = 1'b1;
      rd_d = '0;
      if (PADDR == OFF_ADDR) begin
         rd_d = addr_q;
      end else if (PADDR == OFF_WDATA) begin
         rd_d = wdata_q;
      end else if (PADDR == OFF_CMD) begin
         rd_d = {27'h0, op_q};
      end else if (PADDR == OFF_STAT) begin
         rd_d = {30'h0, fail_q, ~idle};
      end else if (PADDR == OFF_RIS) begin
         rd_d = {25'h0, ris_q};
      end else if (PADDR == OFF_IM) begin
         rd_d = {25'h0, im_q};
      end else if (PADDR == OFF_MIS) begin
         rd_d = {25'h0, ris_q & im_q};
      end else if (PADDR == OFF_ICLR) begin
         rd_d = '0;
      end else if (PADDR == OFF_PROT) begin
         rd_d = {30'h0, cur_prot};
      end else if (PADDR == OFF_USER0) begin
         rd_d = user0_q;
      end else if (PADDR == OFF_USER1) begin
         rd_d = user1_q;
      end else if (PADDR == OFF_RDATA) begin
         rd_d = rdata_q;
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         prdata_q <= '0;
      end else if (rd_setup) begin
         prdata_q <= rd_d;
      end
   end

   // ----------------------------------------------------------------
   // address and protection checks
   // ----------------------------------------------------------------
   assign word_idx = addr_q[AW+1:2];
   assign blk = word_idx[AW-1:OW];
   assign cur_prot = prot_q[blk];
   assign new_prot = PWDATA[1:0];
   assign in_range = (addr_q[31:AW+2] == '0);
   assign aligned = (addr_q[1:0] == 2'h0);
   assign addr_ok = in_range & aligned;
   // tighten only; fetch-only is final; code 3 is invalid
   assign prot_ok = (new_prot <= prot_fetch_only) & (cur_prot != prot_fetch_only)
      & (new_prot >= cur_prot);

   always_comb begin
      cmd_sel = '0;
      if (PWDATA[CMD_PROG]) begin
         cmd_sel[CMD_PROG] = 1'b1;
      end else if (PWDATA[CMD_ERASE]) begin
         cmd_sel[CMD_ERASE] = 1'b1;
      end else if (PWDATA[CMD_READ]) begin
         cmd_sel[CMD_READ] = 1'b1;
      end else if (PWDATA[CMD_PSAVE]) begin
         cmd_sel[CMD_PSAVE] = 1'b1;
      end else if (PWDATA[CMD_USAVE]) begin
         cmd_sel[CMD_USAVE] = 1'b1;
      end
   end

   assign refuse_addr = cmd_wr & idle & ~addr_ok
      & (cmd_sel[CMD_PROG] | cmd_sel[CMD_ERASE] | cmd_sel[CMD_READ]);
   assign refuse_prot = cmd_wr & idle & addr_ok
      & (((cmd_sel[CMD_PROG] | cmd_sel[CMD_ERASE]) & (cur_prot != prot_full_access))
      | (cmd_sel[CMD_READ] & (cur_prot == prot_fetch_only)));
   assign go = cmd_wr & idle & (cmd_sel != '0) & ~refuse_addr & ~refuse_prot;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   assign data_bad = ((~mif.rdata & wdata_q) != '0);
   assign prog_end = (state_q == st_check) & op_q[CMD_PROG];
   assign erase_end = (state_q == st_erase) & (VOLT_ERR | (cnt_q == LAST_WORD));

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_q <= st_idle;
         op_q <= '0;
         op_word_q <= '0;
         cnt_q <= '0;
         save_cnt_q <= '0;
      end else begin
         case (state_q)
            st_idle: begin
               if (go) begin
                  op_q <= cmd_sel;
                  op_word_q <= word_idx;
                  cnt_q <= '0;
                  save_cnt_q <= SW'(SAVE_CYC - 1);
                  if (cmd_sel[CMD_PROG] | cmd_sel[CMD_READ]) begin
                     state_q <= st_fetch;
                  end else if (cmd_sel[CMD_ERASE]) begin
                     state_q <= st_erase;
                  end else begin
                     state_q <= st_save;
                  end
               end
            end
            st_fetch: begin
               state_q <= st_check;
            end
            st_check: begin
               state_q <= st_idle;
            end
            st_erase: begin
               cnt_q <= cnt_q + 1'b1;
               if (erase_end) begin
                  state_q <= st_idle;
               end
            end
            st_save: begin
               save_cnt_q <= save_cnt_q - 1'b1;
               if (save_cnt_q == '0) begin
                  state_q <= st_idle;
               end
            end
            default: begin
               state_q <= st_idle;
            end
         endcase
      end
   end

   assign psave_p = (state_q == st_save) & (save_cnt_q == '0) & op_q[CMD_PSAVE];
   assign usave_p = (state_q == st_save) & (save_cnt_q == '0) & op_q[CMD_USAVE];
   assign BUSY = ~idle;

   // ----------------------------------------------------------------
   // memory port
   // ----------------------------------------------------------------
   assign mif.we = (prog_end & ~VOLT_ERR & ~data_bad) | ((state_q == st_erase) & ~VOLT_ERR);
   assign mif.waddr = (state_q == st_erase) ? {op_word_q[AW-1:OW], cnt_q} : op_word_q;
   assign mif.wdata = (state_q == st_erase) ? ERASED_WORD
      : (mif.rdata & wdata_q);
   assign mif.re = idle ? IF_REQ : (state_q == st_fetch);
   assign mif.raddr = idle ? IF_ADDR[AW+1:2] : op_word_q;
   assign IF_READY = idle;
   assign IF_RDATA = mif.rdata;
   assign IF_RVALID = if_rvalid_q;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         if_rvalid_q <= 1'b0;
      end else begin
         if_rvalid_q <= idle & IF_REQ;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_q <= '0;
      end else if ((state_q == st_check) & op_q[CMD_READ]) begin
         rdata_q <= mif.rdata;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         addr_q <= '0;
         wdata_q <= '0;
         im_q <= IM_RESET;
      end else begin
         if (wr_acc & idle & (PADDR == OFF_ADDR)) begin
            addr_q <= PWDATA;
         end
         if (wr_acc & idle & (PADDR == OFF_WDATA)) begin
            wdata_q <= PWDATA;
         end
         if (wr_acc & (PADDR == OFF_IM)) begin
            im_q <= PWDATA[NINT-1:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         user0_q <= nv_user0;
         user1_q <= nv_user1;
      end else begin
         if (wr_acc & idle & (PADDR == OFF_USER0)) begin
            user0_q <= PWDATA;
         end
         if (wr_acc & idle & (PADDR == OFF_USER1)) begin
            user1_q <= PWDATA;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         prot_q <= nv_prot;
      end else if (prot_wr & prot_ok) begin
         prot_q[blk] <= new_prot;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         fail_q <= 1'b0;
      end else if (go) begin
         fail_q <= 1'b0;
      end else if (refuse_addr | refuse_prot | (prot_wr & ~prot_ok)) begin
         fail_q <= 1'b1;
      end else if ((prog_end & (VOLT_ERR | data_bad)) | ((state_q == st_erase) & VOLT_ERR)) begin
         fail_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   always_comb begin
      set_v = '0;
      set_v[INT_ACCESS] = refuse_prot;
      set_v[INT_DONE] = prog_end | erase_end;
      set_v[INT_NVS] = NVS_EVT;
      set_v[INT_VOLT] = VOLT_ERR & (prog_end | (state_q == st_erase));
      set_v[INT_DATA] = prog_end & data_bad;
      set_v[INT_ERASE] = (state_q == st_erase) & VOLT_ERR;
      set_v[INT_PROG] = prog_end & (VOLT_ERR | data_bad);
   end
   assign clr_v = (wr_acc & (PADDR == OFF_ICLR)) ? PWDATA[NINT-1:0] : '0;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ris_q <= RIS_RESET;
      end else begin
         ris_q <= (ris_q & ~clr_v) | set_v;
      end
   end
   assign IRQ = |(ris_q & im_q);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_ACCESS_FLAG: assert property (@(posedge CLK) disable iff (RESET)
      refuse_prot |=> ris_q[INT_ACCESS] && state_q == st_idle)
      else $error("access violation not flagged");
   AST_ERASE_DONE: assert property (@(posedge CLK) disable iff (RESET)
      (idle && go && cmd_sel[CMD_ERASE] && !VOLT_ERR) ##1 (!VOLT_ERR) [*8]
      |-> ##[8:9] ris_q[INT_DONE])
      else $error("erase completion not flagged");
   AST_MASKED_IRQ: assert property (@(posedge CLK) disable iff (RESET)
      ((ris_q & im_q) == '0) |-> !IRQ)
      else $error("disabled source reaches interrupt");
   AST_STICKY: assert property (@(posedge CLK) disable iff (RESET)
      ris_q[INT_DATA] && !clr_v[INT_DATA] |=> ris_q[INT_DATA])
      else $error("raw status dropped without clear");
   AST_PROG_ONLY_CLEARS: assert property (@(posedge CLK) disable iff (RESET)
      (mif.we && state_q == st_check) |-> ((mif.wdata & ~mif.rdata) == '0))
      else $error("program sets a zero bit");
   AST_ERASE_ONES: assert property (@(posedge CLK) disable iff (RESET)
      (mif.we && state_q == st_erase) |-> mif.wdata == ERASED_WORD)
      else $error("erase word not all ones");
   AST_NO_LOOSEN: assert property (@(posedge CLK) disable iff (RESET)
      (prot_wr && new_prot < cur_prot) |=> $stable(prot_q) && fail_q)
      else $error("protection loosened");
   AST_FETCH_FINAL: assert property (@(posedge CLK) disable iff (RESET)
      (prot_wr && cur_prot == prot_fetch_only) |=> $stable(prot_q))
      else $error("fetch-only block changed");
   AST_DATA_ERR: assert property (@(posedge CLK) disable iff (RESET)
      (prog_end && data_bad) |-> !mif.we ##1 ris_q[INT_DATA] && ris_q[INT_PROG])
      else $error("data error missed");
   AST_BUSY_HOLD: assert property (@(posedge CLK) disable iff (RESET)
      (cmd_wr && !idle) |=> $stable(op_q) && $stable(op_word_q))
      else $error("command taken while busy");
endmodule : fpp_ctrl

// ==== testbench/fpp_core_model.sv ====
// processor-side fetch requester for the controller
// assumes a ready/valid fetch port sampled on the rising clock
`timescale 1ns/1ps
module fpp_core_model (
   input wire logic clk,
   input wire logic start,
   input wire logic [31:0] addr,
   input wire logic if_ready,
   input wire logic if_rvalid,
   input wire logic [31:0] if_rdata,
   output logic if_req,
   output logic [31:0] if_addr,
   output logic [31:0] data,
   output logic got
);
   initial begin
      if_req = 1'b0;
      if_addr = 32'h0;
      data = 32'h0;
      got = 1'b0;
   end
   always @(posedge clk) begin
      got <= 1'b0;
      if (start && !if_req) begin
         if_req <= 1'b1;
         if_addr <= addr;
      end else if (if_req && if_ready) begin
         if_req <= 1'b0;
         if_addr <= ~if_addr;
      end
      if (if_rvalid) begin
         data <= if_rdata;
         got <= 1'b1;
      end
   end
endmodule : fpp_core_model

// ==== testbench/fpp_ctrl_tb.sv ====
// self-checking bench of the flash protect and program controller
// assumes default parameters: 16 blocks of 16 words
`timescale 1ns/1ps
module fpp_ctrl_tb;
   import fpp_pkg::*;
   logic CLK, RESET, COLD_RESET, psel, pen, pwr, pready, pslverr, nvs, volt, start;
   logic busy, irq, ifreq, ifrdy, ifrv, got, e;
   logic [7:0] paddr;
   logic [31:0] pwd, prd, r, w, v, ifa, ifd, fd;
   int n_errors, n_checks;
   fpp_ctrl DUT (.CLK(CLK), .RESET(RESET), .COLD_RESET(COLD_RESET), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(pready), .PSLVERR(pslverr), .IF_REQ(ifreq), .IF_ADDR(ifa),
      .IF_READY(ifrdy), .IF_RVALID(ifrv), .IF_RDATA(ifd), .NVS_EVT(nvs),
      .VOLT_ERR(volt), .BUSY(busy), .IRQ(irq));
   fpp_core_model core (.clk(CLK), .start(start), .addr(32'h44), .if_ready(ifrdy),
      .if_rvalid(ifrv), .if_rdata(ifd), .if_req(ifreq), .if_addr(ifa), .data(fd), .got(got));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function logic [31:0] exp_word(input logic [31:0] o, input logic [31:0] n);
      return ((~o & n) != 0) ? o : (o & n);
   endfunction : exp_word
   function logic [31:0] exp_ris(input logic [31:0] o, input logic [31:0] n);
      return ((~o & n) != 0) ? 32'h52 : 32'h02;
   endfunction : exp_ris
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task apb(input logic wi, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wi;
      paddr <= a;
      pwd <= d;
      @(posedge CLK);
      pen <= 1'b1;
      do @(posedge CLK); while (pready !== 1'b1);
      r = prd;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task wt();
      for (int i = 0; i < 50; i++) begin
         rd(OFF_STAT);
         if (r[STAT_BUSY] === 1'b0) break;
      end
      chk(r & 32'h1, 32'h0);
   endtask : wt
   task op(input int b, input logic [31:0] a, input logic [31:0] d);
      wr(OFF_ADDR, a);
      wr(OFF_WDATA, d);
      wr(OFF_CMD, 32'h1 << b);
      wt();
      if (b == CMD_READ) rd(OFF_RDATA);
   endtask : op
   task wrap_up();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      repeat (20000) @(posedge CLK);
      n_errors++;
      wrap_up();
   end
   initial begin
      {RESET, COLD_RESET, psel, pen, pwr, nvs, volt, start} = 8'h c0;
      paddr = 8'h00;
      pwd = 32'h0;
      void'($urandom(42013));
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      COLD_RESET <= 1'b0;
      rd(OFF_RIS); chk(r, 32'h0);
      rd(OFF_IM); chk(r, 32'h0);
      $display("test reset done");
      op(CMD_ERASE, 32'h0, 32'h0);
      rd(OFF_RIS); chk(r, 32'h2);
      op(CMD_READ, 32'h4, 32'h0); chk(r, ERASED_WORD);
      w = $urandom;
      v = w & $urandom;
      op(CMD_PROG, 32'h4, w);
      op(CMD_PROG, 32'h4, v);
      op(CMD_READ, 32'h4, 32'h0); chk(r, exp_word(w, v));
      wr(OFF_ICLR, 32'h7f);
      op(CMD_PROG, 32'h4, ~v);
      rd(OFF_RIS); chk(r, exp_ris(v, ~v));
      op(CMD_READ, 32'h4, 32'h0); chk(r, exp_word(v, ~v));
      $display("test program done");
      op(CMD_ERASE, 32'h40, 32'h0);
      wr(OFF_PROT, prot_no_modify);
      wr(OFF_ICLR, 32'h7f);
      op(CMD_PROG, 32'h44, 32'h0);
      rd(OFF_STAT); chk(r & 32'h2, 32'h2);
      rd(OFF_RIS); chk(r & 32'h1, 32'h1);
      wr(OFF_PROT, prot_full_access);
      rd(OFF_PROT); chk(r, prot_no_modify);
      wr(OFF_PROT, prot_fetch_only);
      rd(OFF_PROT); chk(r, prot_fetch_only);
      wr(OFF_PROT, prot_no_modify);
      rd(OFF_PROT); chk(r, prot_fetch_only);
      wr(OFF_ICLR, 32'h7f);
      op(CMD_READ, 32'h44, 32'h0);
      rd(OFF_RIS); chk(r & 32'h1, 32'h1);
      start <= 1'b1;
      @(posedge CLK);
      start <= 1'b0;
      for (int i = 0; i < 20 && got !== 1'b1; i++) @(posedge CLK);
      chk(fd, ERASED_WORD);
      $display("test protection done");
      wr(OFF_ICLR, 32'h7f);
      nvs <= 1'b1;
      @(posedge CLK);
      nvs <= 1'b0;
      w = $urandom & 32'h7f;
      wr(OFF_IM, w);
      rd(OFF_RIS); chk(r, 32'h4);
      rd(OFF_MIS); chk(r, 32'h4 & w);
      chk({31'h0, e}, 32'h0);
      rd(8'h30); chk({31'h0, e}, 32'h1);
      chk({31'h0, irq}, {31'h0, w[INT_NVS]});
      wr(OFF_ICLR, 32'h4);
      rd(OFF_RIS); chk(r, 32'h0);
      wr(OFF_ADDR, 32'h80);
      wr(OFF_CMD, 32'h1 << CMD_ERASE);
      volt <= 1'b1;
      @(posedge CLK);
      volt <= 1'b0;
      wt();
      rd(OFF_RIS); chk(r, (1 << INT_DONE) | (1 << INT_VOLT) | (1 << INT_ERASE));
      rd(OFF_STAT); chk(r & 32'h2, 32'h2);
      $display("test status done");
      w = $urandom;
      v = $urandom;
      wr(OFF_USER0, w);
      wr(OFF_USER1, v);
      rd(OFF_USER0); chk(r, w);
      rd(OFF_USER1); chk(r, v);
      op(CMD_USAVE, 32'h0, 32'h0);
      wr(OFF_USER0, 32'h0);
      op(CMD_PSAVE, 32'h0, 32'h0);
      wr(OFF_ADDR, 32'hc0);
      wr(OFF_CMD, 32'h1 << CMD_ERASE);
      @(negedge CLK);
      chk({31'h0, busy}, 32'h1);
      wr(OFF_PROT, prot_no_modify);
      wr(OFF_USER1, 32'h0);
      wr(OFF_CMD, 32'h1 << CMD_PROG);
      wt();
      rd(OFF_USER1); chk(r, v);
      rd(OFF_PROT); chk(r, prot_full_access);
      rd(OFF_CMD); chk(r, 32'h1 << CMD_ERASE);
      wr(OFF_PROT, prot_no_modify);
      rd(OFF_PROT); chk(r, prot_no_modify);
      RESET <= 1'b1;
      repeat (3) @(posedge CLK);
      RESET <= 1'b0;
      rd(OFF_USER0); chk(r, w);
      wr(OFF_ADDR, 32'hc0);
      rd(OFF_PROT); chk(r, prot_full_access);
      wr(OFF_ADDR, 32'h40);
      rd(OFF_PROT); chk(r, prot_fetch_only);
      $display("test save done");
      wrap_up();
   end
endmodule : fpp_ctrl_tb
